/* File: src/hub_port_ctrl.sv */
// hub_port_ctrl: hub control for up to four downstream ports, with boot
// configuration, upstream attach state, port machines, power and leds.
// assumes frame, repeater and bus reset strobes come from core-clock logic;
// strap, attach, line state and overcurrent pins are asynchronous.
`timescale 1ns/1ps

// Overview of operation
// - configuration from straps/defaults, or eeprom only after checksum passes
// - pull-up on once configuration is loaded, then wait for bus reset
// - bus reset clears address and configuration value to zero
// - full hub behaviour only with a nonzero configuration set by host
// - upstream repeater traffic blocked from ports not cleanly enabled
// - four ports; usable count and removable mask from eeprom or straps
// - unconfigured hub drives SE0 and keeps every port unpowered
// - configured hub releases lines; SetPortPower powers the named port if within the usable count
// - connect, disconnect and port changes flagged on endpoint 1 map
// - port reset drives reset, then enables, then arms babble checks
// - non-idle line after EOF2 on an enabled port disables it
// - ClearPortEnable disables the named port
// - SetPortSuspend suspends only the named port
// - remote wake: change flag if hub active, forwarded if suspended
// - ClearPortSuspend resumes the named suspended port
// - strap selects ganged or per-port power switch control
// - strap selects active level of power switch enables
// - overcurrent reported to host and power switch enable dropped
// - enable drops three to four milliseconds after overcurrent seen
// - hub characteristics advertise indicators in bit 7
// - indicators start automatic: green, amber or off by port status
// - all indicators off while the hub is suspended
module hub_port_ctrl #(
  parameter int RESET_CYCLES = hub_port_pkg::PORT_RESET_CYCLES,
  parameter int OC_CYCLES = hub_port_pkg::OC_DELAY_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire hub_port_pkg::reg_req_t reg_req_i,
  output logic [31:0] reg_rdata_o,
  input wire logic ee_absent_i,
  input wire logic ee_valid_i,
  input wire logic [7:0] ee_data_i,
  input wire logic ee_last_i,
  input wire hub_port_pkg::straps_t straps_i,
  input wire logic usb_bus_reset_i,
  input wire logic hub_suspend_i,
  input wire logic frame_eof2_i,
  input wire logic frame_sof_i,
  input wire logic rpt_up_active_i,
  input wire logic [1:0] rpt_up_src_i,
  input wire logic [3:0] dn_attach_i,
  input wire logic [3:0][1:0] dn_linestate_i,
  input wire logic [3:0] port_overcurrent_sense_n_i,
  output logic up_pullup_en_o,
  output logic up_tx_block_o,
  output logic remote_wake_o,
  output logic hub_configured_o,
  output logic [4:0] ep1_change_map_o,
  output logic [15:0] hub_char_o,
  output logic [3:0] dn_se0_o,
  output logic [3:0] port_power_switch_enable_o,
  output logic [3:0] led_green_o,
  output logic [3:0] led_amber_o
);

  localparam int NP = hub_port_pkg::NPORTS;
  localparam int TW = hub_port_pkg::TMR_W;

  hub_port_pkg::state_t s;
  hub_port_pkg::state_t n;
  logic configured;
  logic [NP-1:0] kill;
  logic [NP-1:0] port_kill;
  logic [NP-1:0] port_on;
  logic cmd_ok;
  logic [3:0] cmd_code;
  logic [1:0] cmd_port;
  logic [1:0] cmd_colour;

  assign configured = (s.up == hub_port_pkg::UP_DEFAULT) &&
                      (s.cfg_value != 8'h00);

  // host requests reach ports only on a configured hub
  assign cmd_ok = reg_req_i.we && configured &&
                  (reg_req_i.addr == hub_port_pkg::REG_COMMAND);
  assign cmd_code = reg_req_i.wdata[hub_port_pkg::CMD_CODE_LSB +: 4];
  assign cmd_port = reg_req_i.wdata[hub_port_pkg::CMD_PORT_LSB +: 2];
  assign cmd_colour = reg_req_i.wdata[hub_port_pkg::CMD_COLOUR_LSB +: 2];

  // overcurrent shutdown strobe per port; ganged mode shares one switch
  genvar g;
  generate
    for (g = 0; g < NP; g++) begin : g_port
      assign kill[g] = s.port[g].oc_pend && (s.port[g].oc_tmr == TW'(1));
      assign port_kill[g] = s.strap_s2.gang ? (|kill) : kill[g];
      assign port_on[g] = s.port[g].st != hub_port_pkg::P_UNPOWERED;
    end
  endgenerate

  // next-state of the whole block
  always_comb begin
    logic usable;
    logic me;
    logic [8:0] sum9;
    n = s;
    usable = 1'b0;
    me = 1'b0;
    sum9 = '0;
    n.rdata = '0;
    n.wake = 1'b0;
    n.strap_s1 = straps_i;
    n.strap_s2 = s.strap_s1;
    if (s.boot != 2'(hub_port_pkg::BOOT_WAIT)) begin
      n.boot = s.boot + 2'd1;
    end

    if (!s.loaded && s.boot == 2'(hub_port_pkg::BOOT_WAIT)) begin
      if (ee_absent_i) begin
        n.loaded = 1'b1;
        n.nports = {1'b0, s.strap_s2.count_m1} + 3'd1;
        n.removable = ~s.strap_s2.fixed;
      end else if (ee_valid_i) begin
        sum9 = {1'b0, s.ee_sum} + {1'b0, ee_data_i};
        n.ee_sum = sum9[7:0];
        n.ee_first = 1'b0;
        if (s.ee_first) begin
          n.ee_cfg = ee_data_i;
        end
        if (ee_last_i) begin
          n.loaded = 1'b1;
          if (sum9[7:0] == 8'h00 && !s.ee_first &&
              s.ee_cfg[2:0] != 3'd0 && s.ee_cfg[2:0] <= 3'(NP)) begin
            n.from_ee = 1'b1;
            n.nports = s.ee_cfg[2:0];
            n.removable = s.ee_cfg[7:4];
          end else begin
            n.ee_bad = 1'b1;
            n.nports = {1'b0, s.strap_s2.count_m1} + 3'd1;
            n.removable = ~s.strap_s2.fixed;
          end
        end
      end
    end

    case (s.up)
      hub_port_pkg::UP_DETACHED: begin
        if (s.loaded) begin
          n.up = hub_port_pkg::UP_WAIT_RESET;
        end
      end
      hub_port_pkg::UP_WAIT_RESET: begin
        if (usb_bus_reset_i) begin
          n.up = hub_port_pkg::UP_DEFAULT;
        end
      end
      hub_port_pkg::UP_DEFAULT: begin
      end
      default: begin
        n.up = hub_port_pkg::UP_DETACHED;
      end
    endcase

    // address and configuration written by the enumeration firmware
    if (reg_req_i.we && s.up == hub_port_pkg::UP_DEFAULT) begin
      if (reg_req_i.addr == hub_port_pkg::REG_ADDRESS) begin
        n.address = reg_req_i.wdata[6:0];
      end
      if (reg_req_i.addr == hub_port_pkg::REG_CONFIG) begin
        n.cfg_value = reg_req_i.wdata[7:0];
      end
    end
    if (usb_bus_reset_i) begin
      n.address = '0;
      n.cfg_value = '0;
    end

    // babble window runs from EOF2 to the next start of frame
    if (frame_eof2_i) begin
      n.bab_win = 1'b1;
    end else if (frame_sof_i) begin
      n.bab_win = 1'b0;
    end

    // change bits: write one to clear, a new event in the same cycle wins
    if (reg_req_i.we && reg_req_i.addr == hub_port_pkg::REG_CHANGE) begin
      n.chg = s.chg & ~reg_req_i.wdata[4:1];
    end

    for (int p = 0; p < NP; p++) begin
      usable = 3'(p) < s.nports;
      me = cmd_ok && (cmd_port == 2'(p));
      // pin synchronisers, second stage only is read
      n.port[p].ls_s1 = dn_linestate_i[p];
      n.port[p].ls_s2 = s.port[p].ls_s1;
      n.port[p].att_s1 = dn_attach_i[p];
      n.port[p].att_s2 = s.port[p].att_s1;
      n.port[p].oc_s1 = ~port_overcurrent_sense_n_i[p];
      n.port[p].oc_s2 = s.port[p].oc_s1;

      if (s.port[p].oc_s2 == s.port[p].oc_flt) begin
        n.port[p].oc_cnt = '0;
      end else if (s.port[p].oc_cnt ==
                   5'(hub_port_pkg::OC_FILTER_CYCLES - 1)) begin
        n.port[p].oc_cnt = '0;
        n.port[p].oc_flt = s.port[p].oc_s2;
        n.port[p].oc_stat = s.port[p].oc_s2;
        if (s.port[p].oc_s2) begin
          n.chg[p] = 1'b1;
          if (port_on[p]) begin
            n.port[p].oc_pend = 1'b1;
            n.port[p].oc_tmr = TW'(OC_CYCLES);
          end
        end
      end else begin
        n.port[p].oc_cnt = s.port[p].oc_cnt + 5'd1;
      end
      if (s.port[p].oc_pend) begin
        n.port[p].oc_tmr = s.port[p].oc_tmr - TW'(1);
        if (kill[p]) begin
          n.port[p].oc_pend = 1'b0;
        end
      end

      if (me && cmd_code == hub_port_pkg::CMD_SET_INDICATOR) begin
        n.port[p].colour = cmd_colour;
      end

      case (s.port[p].st)
        hub_port_pkg::P_UNPOWERED: begin
          if (me && usable && cmd_code == hub_port_pkg::CMD_SET_POWER) begin
            n.port[p].st = hub_port_pkg::P_POWERED;
            n.port[p].err = 1'b0;
          end
        end
        hub_port_pkg::P_POWERED: begin
          if (s.port[p].att_s2) begin
            n.port[p].st = hub_port_pkg::P_DISABLED;
            n.chg[p] = 1'b1;
          end
        end
        hub_port_pkg::P_DISABLED: begin
          if (me && cmd_code == hub_port_pkg::CMD_SET_RESET) begin
            n.port[p].st = hub_port_pkg::P_RESETTING;
            n.port[p].tmr = TW'(RESET_CYCLES);
            n.port[p].err = 1'b0;
            n.port[p].colour = hub_port_pkg::IND_AUTO;
          end
        end
        hub_port_pkg::P_RESETTING: begin
          n.port[p].tmr = s.port[p].tmr - TW'(1);
          if (s.port[p].tmr == TW'(1)) begin
            n.port[p].st = hub_port_pkg::P_ENABLED;
            n.chg[p] = 1'b1;
          end
        end
        hub_port_pkg::P_ENABLED: begin
          if (s.bab_win && s.port[p].ls_s2 != hub_port_pkg::LS_J) begin
            n.port[p].st = hub_port_pkg::P_DISABLED;
            n.port[p].err = 1'b1;
            n.chg[p] = 1'b1;
          end else if (me && cmd_code == hub_port_pkg::CMD_CLEAR_ENABLE) begin
            n.port[p].st = hub_port_pkg::P_DISABLED;
          end else if (me && cmd_code == hub_port_pkg::CMD_SET_SUSPEND) begin
            n.port[p].st = hub_port_pkg::P_SUSPENDED;
          end
        end
        hub_port_pkg::P_SUSPENDED: begin
          if (me && cmd_code == hub_port_pkg::CMD_CLEAR_SUSPEND) begin
            n.port[p].st = hub_port_pkg::P_ENABLED;
          end else if (me && cmd_code == hub_port_pkg::CMD_CLEAR_ENABLE) begin
            n.port[p].st = hub_port_pkg::P_DISABLED;
          end else if (s.port[p].ls_s2 == hub_port_pkg::LS_K) begin
            n.port[p].st = hub_port_pkg::P_ENABLED;
            if (hub_suspend_i) begin
              n.wake = 1'b1;
            end else begin
              n.chg[p] = 1'b1;
            end
          end
        end
        default: begin
          n.port[p].st = hub_port_pkg::P_UNPOWERED;
        end
      endcase

      if (s.port[p].st > hub_port_pkg::P_POWERED && !s.port[p].att_s2) begin
        n.port[p].st = hub_port_pkg::P_POWERED;
        n.chg[p] = 1'b1;
      end
      if (port_on[p] && me && cmd_code == hub_port_pkg::CMD_CLEAR_POWER) begin
        n.port[p].st = hub_port_pkg::P_UNPOWERED;
      end
      if (port_kill[p] && port_on[p]) begin
        n.port[p].st = hub_port_pkg::P_UNPOWERED;
        n.port[p].err = 1'b1;
      end
      if (!configured || usb_bus_reset_i) begin
        n.port[p].st = hub_port_pkg::P_UNPOWERED;
        n.port[p].oc_pend = 1'b0;
      end

      // SE0 until configured, also during port reset
      n.se0[p] = !configured || (s.port[p].st == hub_port_pkg::P_RESETTING);
      // power drive, ganged or per port
      n.pwr[p] = (s.strap_s2.gang ? (|port_on) : port_on[p]) ^
                 ~s.strap_s2.active_high;

      if (hub_suspend_i) begin
        n.led_g[p] = 1'b0;
        n.led_a[p] = 1'b0;
      end else if (s.port[p].colour != hub_port_pkg::IND_AUTO) begin
        n.led_g[p] = s.port[p].colour == hub_port_pkg::IND_GREEN;
        n.led_a[p] = s.port[p].colour == hub_port_pkg::IND_AMBER;
      end else begin
        n.led_a[p] = s.port[p].err || s.port[p].oc_stat;
        n.led_g[p] = !n.led_a[p] &&
                     (s.port[p].st == hub_port_pkg::P_ENABLED ||
                      s.port[p].st == hub_port_pkg::P_SUSPENDED);
      end
    end

    // read data, valid only in the cycle after the strobe
    if (reg_req_i.re) begin
      case (reg_req_i.addr)
        hub_port_pkg::REG_STATUS: begin
          n.rdata = {18'h00000, s.removable, 1'b0, s.nports, configured,
                     s.up, s.ee_bad, s.from_ee, s.loaded};
        end
        hub_port_pkg::REG_ADDRESS: begin
          n.rdata = {25'h0000000, s.address};
        end
        hub_port_pkg::REG_CONFIG: begin
          n.rdata = {24'h000000, s.cfg_value};
        end
        hub_port_pkg::REG_CHANGE: begin
          n.rdata = {27'h0000000, s.chg, 1'b0};
        end
        hub_port_pkg::REG_PORTS: begin
          for (int p = 0; p < NP; p++) begin
            n.rdata[p*8 +: 8] = {s.port[p].colour, s.port[p].err,
                                 s.port[p].oc_stat, 1'b0, s.port[p].st};
          end
        end
        hub_port_pkg::REG_HUB_CHAR: begin
          n.rdata = {16'h0000, hub_char_o};
        end
        default: begin
          n.rdata = '0;
        end
      endcase
    end
  end

  // single state register
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s <= '0;
      s.ee_first <= 1'b1;
      s.se0 <= '1;
    end else begin
      s <= n;
    end
  end

  // outputs
  assign reg_rdata_o = s.rdata;
  assign up_pullup_en_o = s.up != hub_port_pkg::UP_DETACHED;
  assign hub_configured_o = configured;
  assign remote_wake_o = s.wake;
  assign ep1_change_map_o = {s.chg, 1'b0};
  assign dn_se0_o = s.se0;
  assign port_power_switch_enable_o = s.pwr;
  assign led_green_o = s.led_g;
  assign led_amber_o = s.led_a;
  assign hub_char_o = hub_port_pkg::HUB_CHAR_DEFAULT |
    (16'(!s.strap_s2.gang) << hub_port_pkg::HUB_CHAR_INDIV_BIT);
  // block upstream repeat from ports not enabled
  assign up_tx_block_o = rpt_up_active_i &&
    (s.port[rpt_up_src_i].st != hub_port_pkg::P_ENABLED);

  // checks
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!resetn_i);

  AST_PULLUP_AFTER_LOAD: assert property (
    $rose(up_pullup_en_o) |-> $past(s.loaded, 1))
    else $error("pull-up enabled before configuration load");
  AST_BUS_RESET_CLEARS: assert property (
    usb_bus_reset_i |=> (s.cfg_value == 8'h00) && (s.address == 7'h00)
                        && !hub_configured_o)
    else $error("bus reset left hub configured");
  AST_UNCONFIG_SE0: assert property (
    !configured |=> (dn_se0_o == 4'hf) && (port_on == 4'h0))
    else $error("unconfigured hub released or powered a port");
  AST_BABBLE_DISABLES: assert property (
    (s.port[0].st == hub_port_pkg::P_ENABLED) && s.bab_win &&
    (s.port[0].ls_s2 != hub_port_pkg::LS_J)
    |=> s.port[0].st != hub_port_pkg::P_ENABLED && s.port[0].err == 1'b1
        || s.port[0].st == hub_port_pkg::P_UNPOWERED)
    else $error("babble on enabled port not handled");
  AST_CLEAR_ENABLE: assert property (
    cmd_ok && cmd_port == 2'd0 &&
    cmd_code == hub_port_pkg::CMD_CLEAR_ENABLE &&
    s.port[0].st == hub_port_pkg::P_ENABLED
    |=> s.port[0].st != hub_port_pkg::P_ENABLED)
    else $error("port stayed enabled after disable request");
  AST_SUSPEND_ONE: assert property (
    cmd_ok && cmd_port == 2'd0 && !usb_bus_reset_i &&
    cmd_code == hub_port_pkg::CMD_SET_SUSPEND && !port_kill[0] &&
    s.port[0].st == hub_port_pkg::P_ENABLED && s.port[0].att_s2 &&
    !(s.bab_win && s.port[0].ls_s2 != hub_port_pkg::LS_J)
    |=> s.port[0].st == hub_port_pkg::P_SUSPENDED)
    else $error("suspend request did not suspend the port");
  AST_GANG_SHARED: assert property (
    s.strap_s2.gang && $stable(s.strap_s2.gang)
    |=> (port_power_switch_enable_o == 4'h0) ||
        (port_power_switch_enable_o == 4'hf))
    else $error("ganged enables disagree");
  AST_OC_ARM_TIME: assert property (
    $rose(s.port[0].oc_pend) |-> s.port[0].oc_tmr == TW'(OC_CYCLES))
    else $error("overcurrent delay loaded wrong");
  AST_OC_POWER_OFF: assert property (
    kill[0] && !s.strap_s2.gang && $stable(s.strap_s2.active_high)
    |=> ##1 port_power_switch_enable_o[0] == !s.strap_s2.active_high)
    else $error("power enable not dropped after overcurrent delay");
  AST_LED_SUSPEND: assert property (
    hub_suspend_i |=> (led_green_o == 4'h0) && (led_amber_o == 4'h0))
    else $error("indicators lit while hub suspended");

endmodule : hub_port_ctrl

/* File: src/hub_port_pkg.sv */
// hub_port_pkg: constants, states and carriers of the hub port controller.
// assumes a single 125 MHz core clock shared by every user of the package.
package hub_port_pkg;

  // core clock and derived timing
  localparam int CLK_MHZ = 125;
  localparam int OC_DELAY_MS = 3;
  localparam int OC_DELAY_CYCLES = OC_DELAY_MS * CLK_MHZ * 1000;
  localparam int PORT_RESET_MS = 10;
  localparam int PORT_RESET_CYCLES = PORT_RESET_MS * CLK_MHZ * 1000;
  localparam int OC_FILTER_CYCLES = 16;
  localparam int BOOT_WAIT = 3;
  localparam int TMR_W = 21;
  localparam int NPORTS = 4;

  // register offsets, byte addresses
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_ADDRESS = 8'h04;
  localparam logic [7:0] REG_CONFIG = 8'h08;
  localparam logic [7:0] REG_COMMAND = 8'h0c;
  localparam logic [7:0] REG_CHANGE = 8'h10;
  localparam logic [7:0] REG_PORTS = 8'h14;
  localparam logic [7:0] REG_HUB_CHAR = 8'h18;

  // command register fields
  localparam int CMD_CODE_LSB = 0;
  localparam int CMD_PORT_LSB = 4;
  localparam int CMD_COLOUR_LSB = 8;
  localparam logic [3:0] CMD_SET_POWER = 4'h1;
  localparam logic [3:0] CMD_CLEAR_POWER = 4'h2;
  localparam logic [3:0] CMD_SET_RESET = 4'h3;
  localparam logic [3:0] CMD_CLEAR_ENABLE = 4'h4;
  localparam logic [3:0] CMD_SET_SUSPEND = 4'h5;
  localparam logic [3:0] CMD_CLEAR_SUSPEND = 4'h6;
  localparam logic [3:0] CMD_SET_INDICATOR = 4'h7;

  // indicator selectors: zero returns a port to automatic
  localparam logic [1:0] IND_AUTO = 2'h0;
  localparam logic [1:0] IND_AMBER = 2'h1;
  localparam logic [1:0] IND_GREEN = 2'h2;

  // hub characteristics: indicator bit 7, bit 0 marks per-port power
  localparam logic [15:0] HUB_CHAR_DEFAULT = 16'h0080;
  localparam int HUB_CHAR_INDIV_BIT = 0;

  // line states seen from the downstream transceiver
  localparam logic [1:0] LS_J = 2'h1;
  localparam logic [1:0] LS_K = 2'h2;

  typedef enum logic [1:0] {
    UP_DETACHED = 2'b00,
    UP_WAIT_RESET = 2'b01,
    UP_DEFAULT = 2'b10
  } up_state_t;

  typedef enum logic [2:0] {
    P_UNPOWERED = 3'b000,
    P_POWERED = 3'b001,
    P_DISABLED = 3'b010,
    P_RESETTING = 3'b011,
    P_ENABLED = 3'b100,
    P_SUSPENDED = 3'b101
  } port_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic we;
    logic re;
  } reg_req_t;

  typedef struct packed {
    logic gang;
    logic active_high;
    logic [1:0] count_m1;
    logic [3:0] fixed;
  } straps_t;

  typedef struct packed {
    port_state_t st;
    logic [TMR_W-1:0] tmr;
    logic [TMR_W-1:0] oc_tmr;
    logic [1:0] ls_s1;
    logic [1:0] ls_s2;
    logic att_s1;
    logic att_s2;
    logic oc_s1;
    logic oc_s2;
    logic [4:0] oc_cnt;
    logic oc_flt;
    logic oc_pend;
    logic oc_stat;
    logic err;
    logic [1:0] colour;
  } port_t;

  typedef struct packed {
    port_t [NPORTS-1:0] port;
    straps_t strap_s1;
    straps_t strap_s2;
    logic [1:0] boot;
    logic loaded;
    logic from_ee;
    logic ee_bad;
    logic ee_first;
    logic [7:0] ee_sum;
    logic [7:0] ee_cfg;
    logic [2:0] nports;
    logic [3:0] removable;
    up_state_t up;
    logic [6:0] address;
    logic [7:0] cfg_value;
    logic bab_win;
    logic [NPORTS-1:0] chg;
    logic [NPORTS-1:0] pwr;
    logic [NPORTS-1:0] se0;
    logic [NPORTS-1:0] led_g;
    logic [NPORTS-1:0] led_a;
    logic wake;
    logic [31:0] rdata;
  } state_t;

endpackage : hub_port_pkg

/* File: test/host_model.sv */
// host_model: upstream host stand-in, bus reset and frame strobes.
// assumes the hub core clock; strobes change just after rising edges.
`timescale 1ns/1ps
module host_model (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic bus_reset_req_i,
  output logic usb_bus_reset_o,
  output logic frame_sof_o,
  output logic frame_eof2_o
);
  logic [7:0] fcnt;
  // bus reset on request; frame ticks keep babble window honest
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fcnt <= 8'h00;
      usb_bus_reset_o <= 1'b0;
      frame_sof_o <= 1'b0;
      frame_eof2_o <= 1'b0;
    end else begin
      fcnt <= fcnt + 8'h01;
      usb_bus_reset_o <= bus_reset_req_i;
      frame_eof2_o <= (fcnt == 8'hf0);
      frame_sof_o <= (fcnt == 8'hff);
    end
  end
endmodule : host_model

/* File: test/testbench.sv */
// testbench: boot, enumeration, port reset, port requests, overcurrent
// shutdown and ganged or active-low power switching.
// assumes parameters shrunk to 20 cycles for port reset and oc delay.
`timescale 1ns/1ps
module testbench;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  hub_port_pkg::reg_req_t req = '0;
  hub_port_pkg::straps_t straps = 8'h70; // per-port, active high, 4 ports
  logic brq = 1'b0;
  logic bus_rst, sof, eof2;
  logic [3:0] attach = 4'h0;
  logic [3:0][1:0] ls = {4{2'h1}};
  logic [3:0] oc_n = 4'hf;
  logic [31:0] rdata;
  logic [3:0] se0, pwr, lg, la;
  logic pull, blk, wake, cfgd;
  logic [4:0] chg;
  logic [15:0] hchar;
  int err_count = 0;
  int cmp_count = 0;
  logic [31:0] r;
  logic hub_susp = 1'b0, rpt_act = 1'b0, seen;
  logic [1:0] rpt_src = 2'h0;

  hub_port_ctrl #(.RESET_CYCLES(20), .OC_CYCLES(20)) hub_port_ctrl_i (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .reg_req_i(req),
    .reg_rdata_o(rdata), .ee_absent_i(1'b1), .ee_valid_i(1'b0),
    .ee_data_i(8'h00), .ee_last_i(1'b0), .straps_i(straps),
    .usb_bus_reset_i(bus_rst), .hub_suspend_i(hub_susp),
    .frame_eof2_i(eof2), .frame_sof_i(sof), .rpt_up_active_i(rpt_act),
    .rpt_up_src_i(rpt_src), .dn_attach_i(attach), .dn_linestate_i(ls),
    .port_overcurrent_sense_n_i(oc_n), .up_pullup_en_o(pull),
    .up_tx_block_o(blk), .remote_wake_o(wake), .hub_configured_o(cfgd),
    .ep1_change_map_o(chg), .hub_char_o(hchar), .dn_se0_o(se0),
    .port_power_switch_enable_o(pwr), .led_green_o(lg), .led_amber_o(la));
  host_model host_model_i (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .bus_reset_req_i(brq), .usb_bus_reset_o(bus_rst),
    .frame_sof_o(sof), .frame_eof2_o(eof2));

  // 125 MHz core clock
  initial begin
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  task automatic cmp(input logic [31:0] got, exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h", $time, m, got);
    end
  endtask : cmp

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge clk_sys_i);
    req.we <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    req <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b1};
    @(posedge clk_sys_i);
    req.re <= 1'b0;
    #1 d = rdata;
  endtask : rd

  task automatic t_enum();
    rd(hub_port_pkg::REG_STATUS, r);
    cmp({31'h0, pull}, 32'h1, "pull-up");
    cmp({28'h0, r[4:3], r[2], r[0]}, 32'h5, "rom boot");
    cmp({28'h0, se0}, 32'hf, "se0 before config");
    cmp({16'h0, hchar}, 32'h0081, "hub char");
    @(posedge clk_sys_i) brq <= 1'b1;
    @(posedge clk_sys_i) brq <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    rd(hub_port_pkg::REG_CONFIG, r);
    cmp(r, 32'h0, "config after reset");
    wr(hub_port_pkg::REG_ADDRESS, 32'h5);
    wr(hub_port_pkg::REG_CONFIG, 32'h1);
    repeat (3) @(posedge clk_sys_i);
    #1 cmp({26'h0, cfgd, 1'b0, se0}, 32'h20, "configured");
    $display("test enum done");
  endtask : t_enum

  task automatic t_port_reset();
    wr(hub_port_pkg::REG_COMMAND, 32'h1);
    attach <= 4'h1;
    repeat (8) @(posedge clk_sys_i);
    #1 cmp({28'h0, pwr}, 32'h1, "power port0");
    wr(hub_port_pkg::REG_CHANGE, 32'h1e);
    wr(hub_port_pkg::REG_COMMAND, 32'h3);
    repeat (2) @(posedge clk_sys_i);
    #1 cmp({28'h0, se0}, 32'h1, "reset signalled");
    repeat (30) @(posedge clk_sys_i);
    rd(hub_port_pkg::REG_PORTS, r);
    cmp({29'h0, r[2:0]}, 32'h4, "port enabled");
    cmp({27'h0, chg}, 32'h2, "change flag");
    $display("test port reset done");
  endtask : t_port_reset

  // port0 enabled on entry; one-cycle K pulse keeps wake out of babble
  task automatic t_port_ops();
    rpt_act <= 1'b1;
    rpt_src <= 2'h1;
    #1 cmp({31'h0, blk}, 32'h1, "idle port blocked");
    rpt_src <= 2'h0;
    #1 cmp({31'h0, blk}, 32'h0, "enabled port passes");
    rpt_act <= 1'b0;
    wr(hub_port_pkg::REG_COMMAND, 32'h5);
    rd(hub_port_pkg::REG_PORTS, r);
    cmp({29'h0, r[2:0]}, 32'h5, "suspended");
    wr(hub_port_pkg::REG_COMMAND, 32'h6);
    rd(hub_port_pkg::REG_PORTS, r);
    cmp({29'h0, r[2:0]}, 32'h4, "resumed");
    wr(hub_port_pkg::REG_COMMAND, 32'h5);
    hub_susp <= 1'b1;
    ls[0] <= 2'h2;
    @(posedge clk_sys_i) ls[0] <= 2'h1;
    seen = 1'b0;
    repeat (6) begin
      @(posedge clk_sys_i);
      #1 seen = seen | wake;
    end
    cmp({31'h0, seen}, 32'h1, "wake forwarded");
    cmp({24'h0, lg, la}, 32'h0, "leds dark");
    hub_susp <= 1'b0;
    rd(hub_port_pkg::REG_PORTS, r);
    cmp({29'h0, r[2:0]}, 32'h4, "woken");
    wr(hub_port_pkg::REG_COMMAND, 32'h107);
    @(posedge clk_sys_i);
    #1 cmp({24'h0, lg, la}, 32'h1, "manual amber");
    wr(hub_port_pkg::REG_COMMAND, 32'h4);
    rd(hub_port_pkg::REG_PORTS, r);
    cmp({29'h0, r[2:0]}, 32'h2, "host disable");
    wr(hub_port_pkg::REG_COMMAND, 32'h3);
    repeat (30) @(posedge clk_sys_i);
    #1 cmp({24'h0, lg, la}, 32'h10, "auto after reset");
    // SE0 is non-idle; a whole frame passes so the window is hit
    ls[0] <= 2'h0;
    repeat (300) @(posedge clk_sys_i);
    rd(hub_port_pkg::REG_PORTS, r);
    cmp({26'h0, r[5:0]}, 32'h22, "babble disables");
    $display("test port ops done");
  endtask : t_port_ops

  task automatic t_overcurrent();
    oc_n <= 4'he;
    repeat (30) @(posedge clk_sys_i);
    #1 cmp({28'h0, pwr}, 32'h1, "enable held");
    repeat (20) @(posedge clk_sys_i);
    #1 cmp({28'h0, pwr}, 32'h0, "enable dropped");
    rd(hub_port_pkg::REG_PORTS, r);
    cmp({31'h0, r[4]}, 32'h1, "oc reported");
    $display("test overcurrent done");
  endtask : t_overcurrent

  // straps pass two sync stages, so wait before looking at the enables
  task automatic t_gang();
    wr(hub_port_pkg::REG_COMMAND, 32'h11);
    straps <= 8'hf0; // ganged, active high
    repeat (6) @(posedge clk_sys_i);
    #1 cmp({28'h0, pwr}, 32'hf, "ganged on");
    cmp({16'h0, hchar}, 32'h0080, "ganged char");
    straps <= 8'hb0; // ganged, active low
    repeat (6) @(posedge clk_sys_i);
    #1 cmp({28'h0, pwr}, 32'h0, "active low on");
    wr(hub_port_pkg::REG_COMMAND, 32'h12);
    @(posedge clk_sys_i);
    #1 cmp({28'h0, pwr}, 32'hf, "power cleared");
    $display("test gang done");
  endtask : t_gang

  task automatic close_out();
    $display("compares %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out

  // watchdog: the whole run takes well under 2000 cycles
  initial begin
    #50000;
    err_count++;
    close_out();
  end

  initial begin
    repeat (6) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    t_enum();
    t_port_reset();
    t_port_ops();
    t_overcurrent();
    t_gang();
    close_out();
  end
endmodule : testbench
